// ==== load_shed_order_and_display.v ====
// load shedding control with indicator and meter drive
// assumes source pins, links and button are asynchronous; current comes from same-clock logic
//
// How it works
// RQ1: in normal operation each load indicator lit exactly while its relay applies power.
// RQ2: meter shows total measured current in normal operation.
// RQ3: four service indicators; generator, 50 A and 30 A detected automatically.
// RQ4: first 120 V shore appearance enters 30 A mode, 30/20 indicator lit.
// RQ5: a button press toggles shore threshold between 30 A and 20 A.
// RQ6: holding the button enters review, uppermost indicator and its learned current.
// RQ7: further presses step loads; after the sixth, meter returns to total.
// RQ8: generator limit 45 A with rating link fitted, 60 A without.
// RQ9: three order links pick one of eight sequences; all fitted is sequence 1.
// RQ10: sequence is 1 + 4*A absent + 2*B absent + C absent.
// RQ11: sequences 1 to 4 use their fixed relay shedding orders.
// RQ12: sequences 5 to 8 use their fixed relay shedding orders.
// RQ13: six relays, four AC and two DC, each shed once per sequence.
// RQ14: over the limit, shed one load at a time and learn its current drop.
// RQ15: restore when below limit, headroom covers learned value, two minutes passed.
// RQ16: hold-time threshold separates a short press from a hold.
`include "load_shed_defines.vh"
`default_nettype none

module load_shed_order_and_display #(
   parameter SECOND_CYCLES = `SECOND_CYCLES,
   parameter HOLD_CYCLES = `HOLD_CYCLES,
   parameter RESTORE_SECONDS = `RESTORE_DELAY_S
) (
   input wire clk,
   input wire sys_rst,
   input wire genRunning,
   input wire shore240Present,
   input wire shore120Present,
   input wire [6:0] totalAmps,
   input wire serviceSelectN,
   input wire generator_rating_link,
   input wire shed_order_link_a,
   input wire shed_order_link_b,
   input wire shed_order_link_c,
   output reg [5:0] relayOn,
   output reg [5:0] loadLed,
   output reg [3:0] serviceLed,
   output reg [3:0] meterTens,
   output reg [3:0] meterOnes
);
   // ****************************************
   // synchronisers
   // ****************************************
   // every source pin, link and the button passes two flops before any logic reads it
   reg [7:0] syncA_reg;
   reg [7:0] syncB_reg;
   always @(posedge clk) begin
      syncA_reg <= {genRunning, shore240Present, shore120Present, ~serviceSelectN,
         generator_rating_link, shed_order_link_a, shed_order_link_b, shed_order_link_c};
      syncB_reg <= syncA_reg;
   end
   // sources in priority order: generator, then 240 V, then 120 V shore
   wire genSrc = syncB_reg[7];
   wire src240 = syncB_reg[6] & ~genSrc;
   wire src120 = syncB_reg[5] & ~genSrc & ~syncB_reg[6];
   wire managed = genSrc | src120;
   wire buttonDown = syncB_reg[4];

   // a link reads high when fitted
   wire genLinkFitted = syncB_reg[3];
   wire linkAFitted = syncB_reg[2];
   wire linkBFitted = syncB_reg[1];
   wire linkCFitted = syncB_reg[0];
   wire [2:0] seqIdx = {~linkAFitted, ~linkBFitted, ~linkCFitted}; // RQ9 RQ10
   reg mode20_reg;

   // ****************************************
   // functions
   // ****************************************
   // relay shedding order per sequence, three bits per position
   function [17:0] orderOf;
      input [2:0] seq;
      begin
         case (seq)
            3'h0: orderOf = `ORDER_SEQ1; // RQ11
            3'h1: orderOf = `ORDER_SEQ2; // RQ11
            3'h2: orderOf = `ORDER_SEQ3; // RQ11
            3'h3: orderOf = `ORDER_SEQ4; // RQ11
            3'h4: orderOf = `ORDER_SEQ5; // RQ12
            3'h5: orderOf = `ORDER_SEQ6; // RQ12
            3'h6: orderOf = `ORDER_SEQ7; // RQ12
            default: orderOf = `ORDER_SEQ8; // RQ12
         endcase
      end
   endfunction

   // relay number 1..6 shed at a position, returned as bit index 0..5
   function [2:0] relayAt;
      input [17:0] order;
      input [2:0] pos;
      reg [2:0] r;
      begin
         r = order[pos*3 +: 3];
         relayAt = r - 3'h1;
      end
   endfunction

   wire [17:0] order = orderOf(seqIdx);
   wire [6:0] limit = genSrc ? (genLinkFitted ? `LIMIT_GEN_FITTED : `LIMIT_GEN_ABSENT) // RQ8
      : (mode20_reg ? `LIMIT_SHORE_20 : `LIMIT_SHORE_30);

   // ****************************************
   // one second enable
   // ****************************************
   // one enable pulse per second; restore ages and settling count these, the button hold counts clocks
   reg [31:0] secCnt_reg;
   reg secTick_reg;
   always @(posedge clk) begin
      if (sys_rst || secCnt_reg == SECOND_CYCLES - 1) begin
         secCnt_reg <= 32'h0;
      end else begin
         secCnt_reg <= secCnt_reg + 32'h1;
      end
      secTick_reg <= !sys_rst && secCnt_reg == SECOND_CYCLES - 1;
   end

   // ****************************************
   // service select button
   // ****************************************
   reg [31:0] holdCnt_reg;
   reg held_reg;
   reg reviewing_reg;
   reg [2:0] reviewIdx_reg;
   reg prev120_reg;
   // a hold begun outside review has its release masked by held_reg, so it never counts as a short press
   wire shortPress = !buttonDown && holdCnt_reg != 32'h0 && !held_reg;
   always @(posedge clk) begin
      if (sys_rst) begin
         holdCnt_reg <= 32'h0;
         held_reg <= 1'b0;
         reviewing_reg <= 1'b0;
         reviewIdx_reg <= 3'h0;
         mode20_reg <= 1'b0;
         prev120_reg <= 1'b0;
      end else begin
         prev120_reg <= src120;
         if (buttonDown) begin
            if (holdCnt_reg != HOLD_CYCLES) begin
               holdCnt_reg <= holdCnt_reg + 32'h1;
            end
         end else begin
            holdCnt_reg <= 32'h0;
            held_reg <= 1'b0;
         end
         // the 30 A mode returns whenever 120 V shore power reappears
         if (src120 && !prev120_reg) begin
            mode20_reg <= 1'b0; // RQ4
         end else if (shortPress && !reviewing_reg && src120) begin
            mode20_reg <= ~mode20_reg; // RQ5 RQ16
         end
         if (buttonDown && !held_reg && holdCnt_reg == HOLD_CYCLES - 1 && !reviewing_reg) begin
            held_reg <= 1'b1; // RQ16
            reviewing_reg <= 1'b1; // RQ6
            reviewIdx_reg <= 3'h0;
         end else if (shortPress && reviewing_reg) begin
            if (reviewIdx_reg == 3'h5) begin
               reviewing_reg <= 1'b0; // RQ7
            end else begin
               reviewIdx_reg <= reviewIdx_reg + 3'h1; // RQ7
            end
         end
      end
   end

   // ****************************************
   // shedding and restoring
   // ****************************************
   localparam ST_IDLE = 1'b0;
   localparam ST_SETTLE = 1'b1;
   reg state_reg;
   reg [2:0] shedCount_reg;
   reg [5:0] shedMask_reg;
   reg [6:0] beforeAmps_reg;
   reg [2:0] lastRelay_reg;
   reg learnPending_reg;
   reg settleArmed_reg;
   reg [6:0] age_reg [0:5];
   wire [6:0] learnedAmps;
   wire [2:0] candidate = relayAt(order, shedCount_reg - 3'h1);
   wire [2:0] nextShed = relayAt(order, shedCount_reg);
   wire [6:0] memRdAddrFull = {4'h0, reviewing_reg ? reviewIdx_reg : candidate};
   wire [6:0] headroom = limit - totalAmps;
   wire [6:0] drop = (beforeAmps_reg > totalAmps) ? beforeAmps_reg - totalAmps : 7'h0;
   wire memWr = state_reg == ST_SETTLE && secTick_reg && settleArmed_reg && learnPending_reg;
   // restore waits while reviewing: the memory read port serves the display then
   wire canRestore = shedCount_reg != 3'h0 && totalAmps < limit && !reviewing_reg
      && headroom >= learnedAmps && age_reg[candidate] >= RESTORE_SECONDS; // RQ15

   learned_current_mem #(.WIDTH(7), .DEPTH(6), .AW(3)) learnedMem (
      .clk(clk),
      .wrEn(memWr),
      .wrAddr(lastRelay_reg),
      .wrData(drop),
      .rdAddr(memRdAddrFull[2:0]),
      .rdData(learnedAmps)
   );

   // ages saturate so a long shed cannot wrap back to young
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : ageGen
         always @(posedge clk) begin
            if (sys_rst || (state_reg == ST_IDLE && managed && totalAmps > limit
                  && shedCount_reg != 3'h6 && nextShed == g)) begin
               age_reg[g] <= 7'h0;
            end else if (secTick_reg && age_reg[g] < RESTORE_SECONDS) begin
               age_reg[g] <= age_reg[g] + 7'h1; // RQ15
            end
         end
      end
   endgenerate

   // losing the managed source clears all shed state; loads return with the next source
   always @(posedge clk) begin
      if (sys_rst || !managed) begin
         state_reg <= ST_IDLE;
         shedCount_reg <= 3'h0;
         shedMask_reg <= 6'h0;
         beforeAmps_reg <= 7'h0;
         lastRelay_reg <= 3'h0;
         learnPending_reg <= 1'b0;
         settleArmed_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (totalAmps > limit && shedCount_reg != 3'h6) begin
                  shedMask_reg[nextShed] <= 1'b1; // RQ14 RQ13
                  shedCount_reg <= shedCount_reg + 3'h1;
                  beforeAmps_reg <= totalAmps;
                  lastRelay_reg <= nextShed;
                  learnPending_reg <= 1'b1;
                  settleArmed_reg <= 1'b0;
                  state_reg <= ST_SETTLE;
               end else if (canRestore) begin
                  shedMask_reg[candidate] <= 1'b0; // RQ15
                  shedCount_reg <= shedCount_reg - 3'h1;
                  settleArmed_reg <= 1'b0;
                  learnPending_reg <= 1'b0;
                  state_reg <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               // a tick right after the switch only arms, so the drop is taken after the relay has opened
               if (secTick_reg && settleArmed_reg) begin
                  learnPending_reg <= 1'b0; // RQ14
                  state_reg <= ST_IDLE;
               end else if (secTick_reg) begin
                  settleArmed_reg <= 1'b1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // the meter saturates at its top value rather than wrapping to a small number
   function [7:0] bcdOf;
      input [6:0] amps;
      reg [6:0] sat;
      reg [6:0] t;
      reg [6:0] u;
      begin
         sat = (amps > `METER_MAX) ? `METER_MAX : amps;
         t = sat / 7'hA;
         u = sat - t * 7'hA;
         bcdOf = {t[3:0], u[3:0]};
      end
   endfunction

   wire [6:0] meterVal = reviewing_reg ? learnedAmps : totalAmps;
   wire [7:0] meterBcd = bcdOf(meterVal);
   // 240 V service runs every load unmanaged; with no source every relay opens
   wire [5:0] relayNext = src240 ? 6'h3F : (managed ? ~shedMask_reg : 6'h0);
   always @(posedge clk) begin
      if (sys_rst) begin
         relayOn <= 6'h0;
         loadLed <= 6'h0;
         serviceLed <= 4'h0;
         meterTens <= 4'h0;
         meterOnes <= 4'h0;
      end else begin
         relayOn <= relayNext;
         loadLed <= reviewing_reg ? (6'h1 << reviewIdx_reg) : relayNext; // RQ1 RQ6
         serviceLed[`SVC_GEN] <= genSrc; // RQ3
         serviceLed[`SVC_50A] <= src240; // RQ3
         serviceLed[`SVC_30A] <= src120 && !mode20_reg; // RQ3 RQ4
         serviceLed[`SVC_20A] <= src120 && mode20_reg; // RQ5
         meterTens <= meterBcd[7:4]; // RQ2 RQ6
         meterOnes <= meterBcd[3:0]; // RQ2
      end
   end
endmodule

`default_nettype wire

// ==== load_shed_defines.vh ====
// constants for the load shedding order and display block
// assumes a 50 MHz system clock and amp values in whole amps
`ifndef LOAD_SHED_DEFINES_VH
`define LOAD_SHED_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 20
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define RESTORE_DELAY_S 120
`define HOLD_TIME_MS 1000
`define HOLD_CYCLES (`HOLD_TIME_MS * 1000000 / `CLK_PERIOD_NS)

// ****************************************
// current limits in amps
// ****************************************
`define LIMIT_GEN_FITTED 7'h2D
`define LIMIT_GEN_ABSENT 7'h3C
`define LIMIT_SHORE_30 7'h1E
`define LIMIT_SHORE_20 7'h14
`define METER_MAX 7'h63

// ****************************************
// service indicator bit positions
// ****************************************
`define SVC_GEN 0
`define SVC_50A 1
`define SVC_30A 2
`define SVC_20A 3

// ****************************************
// shed orders, first shed in bits 2:0, relay numbers 1..6
// ****************************************
`define ORDER_SEQ1 {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6}
`define ORDER_SEQ2 {3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h4}
`define ORDER_SEQ3 {3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h4}
`define ORDER_SEQ4 {3'h1, 3'h5, 3'h6, 3'h2, 3'h3, 3'h4}
`define ORDER_SEQ5 {3'h5, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4}
`define ORDER_SEQ6 {3'h1, 3'h2, 3'h3, 3'h5, 3'h4, 3'h6}
`define ORDER_SEQ7 {3'h1, 3'h2, 3'h5, 3'h3, 3'h6, 3'h4}
`define ORDER_SEQ8 {3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h4}

`endif

// ==== learned_current_mem.v ====
// small memory of learned load currents, one word per relay
// assumes one clock; read data is registered, one cycle late
`default_nettype none

module learned_current_mem #(
   parameter WIDTH = 7,
   parameter DEPTH = 6,
   parameter AW = 3
) (
   input wire clk,
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [WIDTH-1:0] wrData,
   input wire [AW-1:0] rdAddr,
   output reg [WIDTH-1:0] rdData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   integer i;

   // contents start at zero so an unlearned load never blocks a restore
   initial begin
      for (i = 0; i < DEPTH; i = i + 1) begin
         mem[i] = {WIDTH{1'b0}};
      end
   end

   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

`default_nettype wire

// ==== load_bank_model.sv ====
// load side and user button of the block: current follows closed relays, button pressed on call
// assumes relay bit i feeds a load of i+5 amps on top of a bench-set base current
`default_nettype none
module load_bank_model (
   input wire logic clk,
   input wire logic [5:0] relayOn,
   input wire logic [6:0] baseAmps,
   output var logic [6:0] totalAmps,
   output var logic serviceSelectN
);
   timeunit 1ns;
   timeprecision 1ns;
   // a load draws only while its relay is closed, so each shed shows as a step down
   always_comb begin
      totalAmps = baseAmps;
      for (int i = 0; i < 6; i++)
         if (relayOn[i])
            totalAmps = totalAmps + 7'(i + 5);
   end
   initial serviceSelectN = 1'b1;
   // active low; the long pause after release lets the display settle before a check
   task automatic press(input int held);
      @(posedge clk);
      #2 serviceSelectN = 1'b0;
      repeat (held) @(posedge clk);
      #2 serviceSelectN = 1'b1;
      repeat (40) @(posedge clk);
      #2;
   endtask
endmodule
`default_nettype wire

// ==== load_shed_order_and_display_chk.sv ====
// checker for the load shed block: lamps, service lamps, shedding pace and restore age
// assumes it is bound to the block top and sees its ports only
`default_nettype none
module load_shed_order_and_display_chk #(
   parameter int SECOND_CYCLES = 10,
   parameter int RESTORE_SECONDS = 3
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic genRunning,
   input wire logic shore240Present,
   input wire logic shore120Present,
   input wire logic [6:0] totalAmps,
   input wire logic serviceSelectN,
   input wire logic [5:0] relayOn,
   input wire logic [5:0] loadLed,
   input wire logic [3:0] serviceLed
);
   timeunit 1ns;
   timeprecision 1ns;
   // a shed can land just before a tick, so one tick of the delay is given away
   localparam int AGE_MIN = (RESTORE_SECONDS - 1) * SECOND_CYCLES;
   logic [5:0] prevRelay;
   logic [5:0] youngMask;
   int age [6];
   wire logic [5:0] dropped = prevRelay & ~relayOn;
   always @(posedge clk) begin
      prevRelay <= relayOn;
      for (int i = 0; i < 6; i++) begin
         // a lost source clears all shedding, so loads may return at once when a source comes back
         if (sys_rst || (!genRunning && !shore120Present && !shore240Present))
            age[i] <= AGE_MIN;
         else if (dropped[i])
            age[i] <= 0;
         else if (age[i] < AGE_MIN)
            age[i] <= age[i] + 1;
      end
   end
   always_comb begin
      for (int i = 0; i < 6; i++)
         youngMask[i] = age[i] < AGE_MIN;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_led_match; loadLed == relayOn || $onehot(loadLed); endproperty
   a_led_match: assert property (p_led_match) else $error("load lamps off relays");
   property p_full_240; (shore240Present && !genRunning)[*6] |-> relayOn == 6'h3F && serviceLed == 4'h2; endproperty
   a_full_240: assert property (p_full_240) else $error("240 source not all on");
   property p_gen_lamp; genRunning[*6] |-> serviceLed == 4'h1; endproperty
   a_gen_lamp: assert property (p_gen_lamp) else $error("generator lamp wrong");
   property p_shore_rise;
      ($rose(shore120Present) && !genRunning && !shore240Present)
         ##1 (shore120Present && !genRunning && !shore240Present && serviceSelectN)[*6] |-> serviceLed == 4'h4;
   endproperty
   a_shore_rise: assert property (p_shore_rise) else $error("shore start not 30 A");
   property p_one_drop; genRunning && $past(genRunning, 5) |-> $countones(dropped) <= 1; endproperty
   a_one_drop: assert property (p_one_drop) else $error("two loads shed at once");
   property p_no_shed; (genRunning && totalAmps <= 7'h2D)[*6] |-> dropped == 6'h00; endproperty
   a_no_shed: assert property (p_no_shed) else $error("shed under limit");
   property p_shed_over; (genRunning && totalAmps > 7'h3C && relayOn == 6'h3F)[*3] |-> ##[0:40] dropped != 6'h00;
   endproperty
   a_shed_over: assert property (p_shed_over) else $error("no shed over limit");
   property p_restore_age; !shore240Present |-> (~prevRelay & relayOn & youngMask) == 6'h00; endproperty
   a_restore_age: assert property (p_restore_age) else $error("load restored too soon");
   c_review: cover property (loadLed == 6'h20 && relayOn == 6'h00);
   c_twenty: cover property (serviceLed == 4'h8);
   c_all_shed: cover property (genRunning && relayOn == 6'h00);
endmodule
bind load_shed_order_and_display load_shed_order_and_display_chk #(.SECOND_CYCLES(SECOND_CYCLES),
   .RESTORE_SECONDS(RESTORE_SECONDS)) chk (.clk(clk), .sys_rst(sys_rst), .genRunning(genRunning),
   .shore240Present(shore240Present), .shore120Present(shore120Present), .totalAmps(totalAmps),
   .serviceSelectN(serviceSelectN), .relayOn(relayOn), .loadLed(loadLed), .serviceLed(serviceLed));
`default_nettype wire

// ==== load_shed_order_and_display_tb.sv ====
// self-checking bench for the load shed block with a current and button model
// assumes short counts: 10-cycle second, 20-cycle hold, 3-second restore delay
`default_nettype none
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin badCount++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module load_shed_order_and_display_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, sysRst, genRunning, shore240Present, shore120Present;
   logic genLink, linkA, linkB, linkC;
   logic [6:0] baseAmps;
   wire logic [6:0] totalAmps;
   wire logic serviceSelectN;
   wire logic [5:0] relayOn, loadLed;
   wire logic [3:0] serviceLed, meterTens, meterOnes;
   int badCount = 0;
   int checksDone = 0;
   // relay numbers per sequence, first shed in the top digit
   logic [23:0] orderTab [8] = '{24'h654321, 24'h465321, 24'h436521, 24'h432651,
      24'h432165, 24'h645321, 24'h463521, 24'h436251};
   localparam int secondCycles = 10;
   localparam int holdCycles = 20;
   localparam int restoreSeconds = 3;
   load_shed_order_and_display #(.SECOND_CYCLES(secondCycles), .HOLD_CYCLES(holdCycles),
      .RESTORE_SECONDS(restoreSeconds)) dut (
      .clk(clk), .sys_rst(sysRst), .genRunning(genRunning), .shore240Present(shore240Present),
      .shore120Present(shore120Present), .totalAmps(totalAmps), .serviceSelectN(serviceSelectN),
      .generator_rating_link(genLink), .shed_order_link_a(linkA), .shed_order_link_b(linkB),
      .shed_order_link_c(linkC), .relayOn(relayOn), .loadLed(loadLed), .serviceLed(serviceLed),
      .meterTens(meterTens), .meterOnes(meterOnes));
   load_bank_model pm (.clk(clk), .relayOn(relayOn), .baseAmps(baseAmps), .totalAmps(totalAmps),
      .serviceSelectN(serviceSelectN));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic endSim;
      $display("checks %0d bad %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // equal=1 waits for the relays to reach v, equal=0 waits for them to leave it
   task automatic waitRelay(input logic [5:0] v, input bit equal);
      int n;
      n = 0;
      while ((relayOn === v) != equal) begin
         if (n == 3000) begin
            badCount++;
            endSim();
         end
         cycles(1);
         n++;
      end
   endtask
   initial begin
      logic [5:0] prev;
      logic [3:0] r;
      sysRst = 1'b1;
      genRunning = 1'b1;
      shore240Present = 1'b0;
      shore120Present = 1'b0;
      {genLink, linkA, linkB, linkC} = 4'hF;
      baseAmps = 7'h00;
      cycles(10);
      sysRst = 1'b0;
      waitRelay(6'h3F, 1);
      cycles(2);
      `CHECK(serviceLed, 4'h1)
      `CHECK({meterTens, meterOnes}, 8'h45)
      `CHECK(loadLed, 6'h3F)
      genLink = 1'b0;
      cycles(4);
      // 55 A lies between the two generator limits; one shed brings it back to 45 A
      baseAmps = 7'h0A;
      cycles(100);
      `CHECK(relayOn, 6'h3F)
      genLink = 1'b1;
      waitRelay(6'h3F, 0);
      `CHECK(relayOn, 6'h1F)
      cycles(40);
      for (int s = 0; s < 8; s++) begin
         // links settle through the synchroniser before any restore may start
         {linkA, linkB, linkC} = ~3'(s);
         cycles(4);
         baseAmps = 7'h00;
         waitRelay(6'h3F, 1);
         baseAmps = 7'h3C;
         for (int k = 0; k < 6; k++) begin
            prev = relayOn;
            waitRelay(prev, 0);
            r = orderTab[s][23 - 4 * k -: 4];
            `CHECK(relayOn, prev & ~(6'h01 << (r - 1)))
            `CHECK(loadLed, relayOn)
         end
         // the last shed learns its current only after a full second
         cycles(40);
      end
      pm.press(30);
      `CHECK(loadLed, 6'h01)
      `CHECK({meterTens, meterOnes}, 8'h05)
      for (int k = 1; k < 6; k++) begin
         pm.press(3);
         `CHECK(loadLed, 6'h01 << k)
         `CHECK({meterTens, meterOnes}, (k == 5) ? 8'h10 : 8'(5 + k))
      end
      pm.press(3);
      `CHECK({meterTens, meterOnes}, 8'h60)
      `CHECK(loadLed, 6'h00)
      baseAmps = 7'h00;
      genRunning = 1'b0;
      shore120Present = 1'b1;
      cycles(10);
      `CHECK(serviceLed, 4'h4)
      pm.press(3);
      `CHECK(serviceLed, 4'h8)
      pm.press(3);
      `CHECK(serviceLed, 4'h4)
      pm.press(3);
      shore120Present = 1'b0;
      cycles(10);
      shore120Present = 1'b1;
      cycles(10);
      `CHECK(serviceLed, 4'h4)
      shore240Present = 1'b1;
      waitRelay(6'h3F, 1);
      `CHECK(serviceLed, 4'h2)
      endSim();
   end
endmodule
`default_nettype wire
